// ### hw/sir_dev.sv
// Device end: serialized interrupt slave sequencer and clock-run request
// Notes on behaviour
// - count link states from each start frame
// - drive request only in its own frame
// - frame ends with recover high, then turnaround
// - recover driven by whoever drove before it
// - start six states; slave may drive first
// - IRQ1 and IRQ12 only for channel one
// - SMI, IRQ6/9/10/11 only channels two, three
// - host stop: idle, then two or three lows
// - mode comes from previous stop frame
// - continuous mode: only host starts cycles
// - quiet mode: device starts cycle on request
// - request clock restart before sending request
// - quiet new request drives clock-run low
// - no clock-run for continuous or data
// - other wake needs use another mechanism
// - interface reset clears sequencer and request flags, keeps the mode
`timescale 1ns/1ps
module sir_dev (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic if_reset,
    input wire logic [1:0] ch1_irq,
    input wire logic [4:0] ch2_irq,
    input wire logic [4:0] ch3_irq,
    sir_link_if.dev link,
    output logic clk_req,
    output logic irq_busy,
    output logic quiet_mode
);
    // Core side, clocked by clk
    typedef struct packed {
        logic [sir_pkg::NFRAMES:1] pend;
        logic ifr;
        logic clk_req;
        logic busy;
        logic q1;
        logic q2;
        logic b1;
        logic b2;
        logic b3;
    } sir_core_t;

    // Link side, clocked by the link clock
    typedef struct packed {
        sir_pkg::sir_dst_t st;
        logic [sir_pkg::PH_W-1:0] phase;
        logic [sir_pkg::FRAME_W-1:0] frame;
        logic drove;
        logic ser_o;
        logic ser_oe;
        logic s1;
        logic s2;
        logic s3;
        logic [sir_pkg::NFRAMES:1] p1;
        logic [sir_pkg::NFRAMES:1] p2;
        logic [sir_pkg::NFRAMES:1] sent;
        logic r1;
        logic r2;
        logic quiet;
        logic [1:0] lowrun;
        logic busy;
    } sir_link_t;

    sir_core_t c;
    sir_core_t next_c;
    sir_link_t l;
    sir_link_t next_l;

    // Channel gating decides which frames a channel may ever claim
    function automatic logic [sir_pkg::NFRAMES:1] map_pend(
        input logic [1:0] a,
        input logic [4:0] b,
        input logic [4:0] d
    );
        logic [sir_pkg::NFRAMES:1] m;
        logic [4:0] bd;
        m = '0;
        bd = b | d;
        m[sir_pkg::F_IRQ1] = a[0];
        m[sir_pkg::F_IRQ12] = a[1];
        m[sir_pkg::F_SMI] = bd[0];
        m[sir_pkg::F_IRQ6] = bd[1];
        m[sir_pkg::F_IRQ9] = bd[2];
        m[sir_pkg::F_IRQ10] = bd[3];
        m[sir_pkg::F_IRQ11] = bd[4];
        return m;
    endfunction : map_pend

    always_comb begin
        logic rise;
        logic newreq;
        rise = 1'b0;
        newreq = 1'b0;
        next_c = c;
        next_c.pend = map_pend(ch1_irq, ch2_irq, ch3_irq);
        next_c.ifr = if_reset;
        next_c.q1 = l.quiet;
        next_c.q2 = c.q1;
        next_c.b1 = l.busy;
        next_c.b2 = c.b1;
        next_c.b3 = c.b2;
        newreq = |(next_c.pend & ~c.pend);
        rise = c.b2 & ~c.b3;
        // Only a quiet-mode request may pull clock-run; the set wins over the busy-rise clear, interface reset wins over both
        if (c.q2 && newreq) begin
            next_c.clk_req = 1'b1;
        end else if (rise) begin
            next_c.clk_req = 1'b0;
        end
        if (if_reset) begin
            next_c.clk_req = 1'b0;
        end
        next_c.busy = (next_c.clk_req | c.b2) & ~if_reset;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    always_comb begin
        logic newreq;
        logic [sir_pkg::PH_W-1:0] last;
        newreq = 1'b0;
        last = '0;
        next_l = l;
        next_l.s1 = link.serirq;
        next_l.s2 = l.s1;
        next_l.s3 = l.s2;
        next_l.p1 = c.pend;
        next_l.p2 = l.p1;
        next_l.r1 = c.ifr;
        next_l.r2 = l.r1;
        newreq = |(l.p2 & ~l.sent);
        unique case (l.st)
            sir_pkg::SIR_D_IDLE: begin
                next_l.ser_oe = 1'b0;
                // Synced view lags the wire by two states, so a host start seen here puts this end at state 3
                if (!l.s2 && l.s3) begin
                    next_l.st = sir_pkg::SIR_D_FRAME;
                    next_l.frame = sir_pkg::START_FRAME;
                    next_l.phase = sir_pkg::DEV_SEEN_PHASE;
                end else if (l.quiet && newreq && l.s2 && l.s3) begin
                    next_l.st = sir_pkg::SIR_D_FRAME;
                    next_l.frame = sir_pkg::START_FRAME;
                    next_l.phase = '0;
                    next_l.ser_oe = 1'b1;
                    next_l.ser_o = 1'b0;
                end
            end
            sir_pkg::SIR_D_FRAME: begin
                last = (l.frame == sir_pkg::START_FRAME) ? sir_pkg::START_LAST : sir_pkg::FRAME_LAST;
                if (l.phase != last) begin
                    next_l.phase = l.phase + 3'h1;
                end else if (l.frame == sir_pkg::LAST_FRAME) begin
                    next_l.st = sir_pkg::SIR_D_STOP;
                    next_l.lowrun = '0;
                end else begin
                    next_l.frame = l.frame + 5'h01;
                    next_l.phase = '0;
                end
                if (next_l.st != sir_pkg::SIR_D_FRAME || next_l.frame == sir_pkg::START_FRAME) begin
                    next_l.ser_oe = 1'b0;
                end else if (next_l.phase == sir_pkg::PH_DRIVE) begin
                    next_l.sent[next_l.frame] = l.p2[next_l.frame];
                    next_l.drove = l.p2[next_l.frame];
                    next_l.ser_oe = l.p2[next_l.frame];
                    next_l.ser_o = 1'b0;
                end else if (next_l.phase == sir_pkg::PH_RECOVER) begin
                    next_l.ser_oe = l.drove;
                    next_l.ser_o = 1'b1;
                end else begin
                    next_l.ser_oe = 1'b0;
                    next_l.drove = 1'b0;
                end
            end
            sir_pkg::SIR_D_STOP: begin
                next_l.ser_oe = 1'b0;
                // Frame 17 recover and turnaround still show in the lagging view; this end never drives frame 17
                if (!l.s2) begin
                    if (l.lowrun != sir_pkg::STOP_LOW_CONT) begin
                        next_l.lowrun = l.lowrun + 2'h1;
                    end
                end else if (l.lowrun != '0) begin
                    next_l.quiet = (l.lowrun == sir_pkg::STOP_LOW_QUIET);
                    next_l.st = sir_pkg::SIR_D_IDLE;
                end
            end
            default: begin
                next_l.st = sir_pkg::SIR_D_IDLE;
                next_l.ser_oe = 1'b0;
            end
        endcase
        if (l.r2) begin
            next_l.st = sir_pkg::SIR_D_IDLE;
            next_l.ser_oe = 1'b0;
            next_l.drove = 1'b0;
            next_l.sent = '0;
            next_l.phase = '0;
            next_l.frame = '0;
        end
        next_l.busy = (next_l.st != sir_pkg::SIR_D_IDLE);
    end

    // Link clock may stop in quiet mode; a device start from idle needs edges, which the clock-run request restores
    always_ff @(posedge link.lclk or negedge rst_b) begin
        if (!rst_b) begin
            l <= '{st: sir_pkg::SIR_D_IDLE, ser_o: 1'b1, s1: 1'b1, s2: 1'b1, s3: 1'b1, default: '0};
        end else begin
            l <= next_l;
        end
    end

    assign link.ser_dev_o = l.ser_o;
    assign link.ser_dev_oe = l.ser_oe;
    assign link.clkrun_o = 1'b0;
    assign link.clkrun_oe = c.clk_req;
    assign clk_req = c.clk_req;
    assign irq_busy = c.busy;
    assign quiet_mode = c.q2;
endmodule : sir_dev

// ### hw/sir_pkg.sv
// Constants and types shared by both ends of the serialized interrupt link
package sir_pkg;
    localparam int FRAME_W = 5;
    localparam int PH_W = 3;
    localparam int NFRAMES = 17;
    localparam logic [PH_W-1:0] PH_DRIVE = 3'h0;
    localparam logic [PH_W-1:0] PH_RECOVER = 3'h1;
    localparam logic [PH_W-1:0] FRAME_LAST = 3'h2;
    localparam logic [PH_W-1:0] HOST_LOW_LAST = 3'h3;
    localparam logic [PH_W-1:0] START_RECOVER = 3'h4;
    localparam logic [PH_W-1:0] START_LAST = 3'h5;
    localparam logic [PH_W-1:0] DEV_SEEN_PHASE = 3'h3;
    localparam logic [PH_W-1:0] STOP_TAIL = 3'h4;
    localparam logic [FRAME_W-1:0] START_FRAME = 5'h00;
    localparam logic [FRAME_W-1:0] FIRST_FRAME = 5'h01;
    localparam logic [FRAME_W-1:0] LAST_FRAME = 5'h11;
    localparam logic [1:0] STOP_LOW_QUIET = 2'h2;
    localparam logic [1:0] STOP_LOW_CONT = 2'h3;
    localparam int F_IRQ1 = 2;
    localparam int F_SMI = 3;
    localparam int F_IRQ6 = 7;
    localparam int F_IRQ9 = 10;
    localparam int F_IRQ10 = 11;
    localparam int F_IRQ11 = 12;
    localparam int F_IRQ12 = 13;
    typedef enum logic [1:0] {
        SIR_D_IDLE = 2'h0,
        SIR_D_FRAME = 2'h1,
        SIR_D_STOP = 2'h3
    } sir_dst_t;
    typedef enum logic [1:0] {
        SIR_H_IDLE = 2'h0,
        SIR_H_START = 2'h1,
        SIR_H_FRAME = 2'h3,
        SIR_H_STOP = 2'h2
    } sir_hst_t;
endpackage : sir_pkg

// ### hw/sir_link_if.sv
// Shared interrupt wire, clock-run wire and link clock between host and device
`timescale 1ns/1ps
interface sir_link_if;
    logic lclk;
    logic ser_dev_o;
    logic ser_dev_oe;
    logic ser_host_o;
    logic ser_host_oe;
    logic clkrun_o;
    logic clkrun_oe;
    logic serirq;
    logic clkrun;
    // Pulled-up wires: low whenever any enabled driver drives low
    assign serirq = ~((ser_dev_oe & ~ser_dev_o) | (ser_host_oe & ~ser_host_o));
    assign clkrun = ~(clkrun_oe & ~clkrun_o);
    modport dev (
        input lclk,
        input serirq,
        output ser_dev_o,
        output ser_dev_oe,
        output clkrun_o,
        output clkrun_oe
    );
    modport host (
        output lclk,
        output ser_host_o,
        output ser_host_oe,
        input serirq,
        input clkrun
    );
endinterface : sir_link_if

// ### hw/sir_host.sv
// Host end: makes the link clock, frames each cycle and collects requests
`timescale 1ns/1ps
module sir_host #(
    parameter int LCLK_HALF = 4,
    parameter int GAP = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start_req,
    input wire logic quiet_next,
    sir_link_if.host link,
    output logic [sir_pkg::NFRAMES:1] irq_seen,
    output logic irq_valid,
    output logic quiet_mode
);
    localparam int HW = $clog2(LCLK_HALF) + 1;
    localparam logic [HW-1:0] HALF_LAST = HW'(LCLK_HALF - 1);
    localparam logic [7:0] GAP_LAST = 8'(GAP);

    typedef struct packed {
        sir_pkg::sir_hst_t st;
        logic [sir_pkg::PH_W-1:0] phase;
        logic [sir_pkg::FRAME_W-1:0] frame;
        logic lclk;
        logic [HW-1:0] hcnt;
        logic ser_o;
        logic ser_oe;
        logic out_o;
        logic out_oe;
        logic s1;
        logic s2;
        logic k1;
        logic k2;
        logic quiet;
        logic [1:0] lown;
        logic [sir_pkg::NFRAMES:1] seen;
        logic [sir_pkg::NFRAMES:1] seen_out;
        logic valid;
        logic [7:0] gap;
    } sir_host_t;

    sir_host_t h;
    sir_host_t next_h;

    always_comb begin
        logic run;
        logic tick;
        run = 1'b0;
        tick = 1'b0;
        next_h = h;
        next_h.s1 = link.serirq;
        next_h.s2 = h.s1;
        next_h.k1 = link.clkrun;
        next_h.k2 = h.k1;
        next_h.valid = 1'b0;
        // Wire drive lags the link clock edge by one clk, so the device never samples a changing wire
        next_h.out_o = h.ser_o;
        next_h.out_oe = h.ser_oe;
        // In quiet idle the clock stops unless clock-run or a start asks for it
        run = !h.quiet || h.st != sir_pkg::SIR_H_IDLE || !h.k2 || start_req || !h.s2;
        if (h.hcnt == HALF_LAST) begin
            next_h.hcnt = '0;
            if (h.lclk) begin
                next_h.lclk = 1'b0;
            end else if (run) begin
                next_h.lclk = 1'b1;
                tick = 1'b1;
            end
        end else begin
            next_h.hcnt = h.hcnt + HW'(1);
        end
        if (tick) begin
            unique case (h.st)
                sir_pkg::SIR_H_IDLE: begin
                    next_h.ser_oe = 1'b0;
                    if (!h.quiet && h.gap != GAP_LAST) begin
                        next_h.gap = h.gap + 8'h01;
                    end
                    if ((!h.quiet && h.gap == GAP_LAST) || start_req) begin
                        next_h.st = sir_pkg::SIR_H_START;
                        next_h.phase = '0;
                        next_h.ser_oe = 1'b1;
                        next_h.ser_o = 1'b0;
                    end else if (!h.s2) begin
                        next_h.st = sir_pkg::SIR_H_START;
                        next_h.phase = 3'h1;
                        next_h.ser_oe = 1'b1;
                        next_h.ser_o = 1'b0;
                    end
                end
                sir_pkg::SIR_H_START: begin
                    next_h.phase = h.phase + 3'h1;
                    if (h.phase == sir_pkg::START_LAST) begin
                        next_h.st = sir_pkg::SIR_H_FRAME;
                        next_h.frame = sir_pkg::FIRST_FRAME;
                        next_h.phase = '0;
                        next_h.seen = '0;
                        next_h.ser_oe = 1'b0;
                    end else if (next_h.phase == sir_pkg::START_RECOVER) begin
                        next_h.ser_o = 1'b1;
                    end else if (next_h.phase == sir_pkg::START_LAST) begin
                        next_h.ser_oe = 1'b0;
                    end
                end
                sir_pkg::SIR_H_FRAME: begin
                    next_h.phase = h.phase + 3'h1;
                    if (h.phase == sir_pkg::PH_DRIVE) begin
                        next_h.seen[h.frame] = !h.s2;
                    end
                    if (h.phase == sir_pkg::FRAME_LAST) begin
                        next_h.phase = '0;
                        next_h.frame = h.frame + 5'h01;
                        if (h.frame == sir_pkg::LAST_FRAME) begin
                            next_h.st = sir_pkg::SIR_H_STOP;
                            next_h.lown = quiet_next ? sir_pkg::STOP_LOW_QUIET : sir_pkg::STOP_LOW_CONT;
                        end
                    end
                end
                sir_pkg::SIR_H_STOP: begin
                    next_h.phase = h.phase + 3'h1;
                    next_h.ser_oe = 1'b0;
                    if (next_h.phase <= 3'(h.lown)) begin
                        next_h.ser_oe = 1'b1;
                        next_h.ser_o = 1'b0;
                    end else if (next_h.phase == 3'(h.lown) + 3'h1) begin
                        next_h.ser_oe = 1'b1;
                        next_h.ser_o = 1'b1;
                    end else if (next_h.phase == 3'(h.lown) + sir_pkg::STOP_TAIL) begin
                        next_h.st = sir_pkg::SIR_H_IDLE;
                        next_h.quiet = (h.lown == sir_pkg::STOP_LOW_QUIET);
                        next_h.seen_out = h.seen;
                        next_h.valid = 1'b1;
                        next_h.gap = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h <= '{st: sir_pkg::SIR_H_IDLE, ser_o: 1'b1, out_o: 1'b1, s1: 1'b1, s2: 1'b1, k1: 1'b1, k2: 1'b1,
                default: '0};
        end else begin
            h <= next_h;
        end
    end

    assign link.lclk = h.lclk;
    assign link.ser_host_o = h.out_o;
    assign link.ser_host_oe = h.out_oe;
    assign irq_seen = h.seen_out;
    assign irq_valid = h.valid;
    assign quiet_mode = h.quiet;
endmodule : sir_host

// ### sim/sir_link_monitor.sv
// Checker for the serialized interrupt wire and the clock-run wire
`timescale 1ns/1ps
module sir_link_monitor (
    input wire logic clk,
    input wire logic lclk,
    input wire logic rst_b,
    input wire logic ser_dev_o,
    input wire logic ser_dev_oe,
    input wire logic ser_host_o,
    input wire logic ser_host_oe,
    input wire logic clkrun_oe,
    input wire logic clkrun
);
    logic dev_lo;
    logic dev_hi;
    logic host_lo;
    logic host_hi;
    logic prev_host_lo;
    logic in_cyc;
    logic [5:0] state_idx;
    assign dev_lo = ser_dev_oe & ~ser_dev_o;
    assign dev_hi = ser_dev_oe & ser_dev_o;
    assign host_lo = ser_host_oe & ~ser_host_o;
    assign host_hi = ser_host_oe & ser_host_o;
    // Last host low of a start frame is always state 3; in_cyc flips at the end of each host low run,
    // so start and stop runs alternate without decoding their length
    always_ff @(posedge lclk or negedge rst_b) begin
        if (!rst_b) begin
            prev_host_lo <= 1'b0;
            in_cyc <= 1'b0;
            state_idx <= 6'h3f;
        end else begin
            prev_host_lo <= host_lo;
            if (prev_host_lo && !host_lo) begin
                in_cyc <= ~in_cyc;
            end
            if (host_lo) begin
                state_idx <= 6'h04;
            end else if (state_idx != 6'h3f) begin
                state_idx <= state_idx + 6'h01;
            end
        end
    end
    frame_slot_a: assert property (@(posedge lclk) disable iff (!rst_b)
        dev_lo && in_cyc |-> state_idx inside {6'h09, 6'h0c, 6'h18, 6'h21, 6'h24, 6'h27, 6'h2a})
        else $error("device drove outside its frames");
    frame_recover_a: assert property (@(posedge lclk) disable iff (!rst_b)
        dev_lo && in_cyc |=> dev_hi)
        else $error("device frame low not followed by recover");
    dev_single_a: assert property (@(posedge lclk) disable iff (!rst_b)
        dev_lo |=> !dev_lo)
        else $error("device held wire low twice");
    dev_recover_a: assert property (@(posedge lclk) disable iff (!rst_b)
        dev_hi |-> $past(dev_lo))
        else $error("device recover without own drive");
    dev_turn_a: assert property (@(posedge lclk) disable iff (!rst_b)
        dev_hi |=> !ser_dev_oe)
        else $error("device kept wire in turnaround");
    host_recover_a: assert property (@(posedge lclk) disable iff (!rst_b)
        host_hi |-> $past(host_lo))
        else $error("host recover without own drive");
    host_turn_a: assert property (@(posedge lclk) disable iff (!rst_b)
        host_hi |=> !ser_host_oe)
        else $error("host kept wire in turnaround");
    no_clash_a: assert property (@(posedge lclk) disable iff (!rst_b)
        !(ser_dev_oe && ser_host_oe))
        else $error("both ends drive the wire");
    host_run_a: assert property (@(posedge lclk) disable iff (!rst_b)
        host_lo [*4] |=> !host_lo)
        else $error("host low run too long");
    clkrun_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        clkrun_oe |-> !clkrun)
        else $error("clock-run driven but wire high");
    clkrun_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(clkrun_oe) |-> ##[1:200] !clkrun_oe)
        else $error("clock-run request never withdrawn");
    cover property (@(posedge lclk) dev_lo && !in_cyc);
    cover property (@(posedge lclk) dev_lo && in_cyc);
    cover property (@(posedge clk) $rose(clkrun_oe));
endmodule : sir_link_monitor

// ### sim/test_serirq_slave_and_clock_request.sv
// Self-checking bench joining host and device ends of the serialized interrupt link
`timescale 1ns/1ps
module test_serirq_slave_and_clock_request;
    logic clk;
    logic rst_b;
    logic if_reset;
    logic start_req;
    logic quiet_next;
    logic [1:0] ch1_irq;
    logic [4:0] ch2_irq;
    logic [4:0] ch3_irq;
    logic clk_req;
    logic irq_busy;
    logic dev_quiet;
    logic host_quiet;
    logic irq_valid;
    logic [sir_pkg::NFRAMES:1] irq_seen;
    logic [sir_pkg::NFRAMES:1] exp_seen;
    int errors;
    int total_checks;
    int k;
    int slot [12];
    sir_link_if link();
    sir_dev u_sir_dev (.clk(clk), .rst_b(rst_b), .if_reset(if_reset), .ch1_irq(ch1_irq), .ch2_irq(ch2_irq),
        .ch3_irq(ch3_irq), .link(link), .clk_req(clk_req), .irq_busy(irq_busy), .quiet_mode(dev_quiet));
    // Short gap keeps continuous cycles close together
    sir_host #(.LCLK_HALF(4), .GAP(4)) u_sir_host (.clk(clk), .rst_b(rst_b), .start_req(start_req),
        .quiet_next(quiet_next), .link(link), .irq_seen(irq_seen), .irq_valid(irq_valid), .quiet_mode(host_quiet));
    sir_link_monitor u_sir_link_monitor (.clk(clk), .lclk(link.lclk), .rst_b(rst_b), .ser_dev_o(link.ser_dev_o),
        .ser_dev_oe(link.ser_dev_oe), .ser_host_o(link.ser_host_o), .ser_host_oe(link.ser_host_oe),
        .clkrun_oe(link.clkrun_oe), .clkrun(link.clkrun));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic bad(input string msg);
        errors++;
        $display("BAD %0t %s", $time, msg);
    endtask : bad
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk_bit(input logic got, input logic want, input string msg);
        total_checks++;
        if (got !== want) begin
            bad(msg);
        end
    endtask : chk_bit
    task automatic chk_vec(input logic [sir_pkg::NFRAMES:1] got, input logic [sir_pkg::NFRAMES:1] want,
        input string msg);
        total_checks++;
        if (got !== want) begin
            bad(msg);
        end
    endtask : chk_vec
    // Bounded wait on a level; running out ends the run
    task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (sig !== lvl) begin
            bad("wait ran out");
            results();
        end
        @(negedge clk);
    endtask : wait_lvl
    // Request bits: ch1 in 1:0, ch2 in 6:2, ch3 in 11:7
    task automatic set_req(input logic [11:0] v);
        {ch3_irq, ch2_irq, ch1_irq} = v;
        exp_seen = '0;
        for (int j = 0; j < 12; j++) begin
            if (v[j]) begin
                exp_seen[slot[j]] = 1'b1;
            end
        end
    endtask : set_req
    initial begin
        slot = '{sir_pkg::F_IRQ1, sir_pkg::F_IRQ12, sir_pkg::F_SMI, sir_pkg::F_IRQ6, sir_pkg::F_IRQ9,
            sir_pkg::F_IRQ10, sir_pkg::F_IRQ11, sir_pkg::F_SMI, sir_pkg::F_IRQ6, sir_pkg::F_IRQ9,
            sir_pkg::F_IRQ10, sir_pkg::F_IRQ11};
        errors = 0;
        total_checks = 0;
        rst_b = 1'b0;
        if_reset = 1'b0;
        start_req = 1'b0;
        quiet_next = 1'b0;
        set_req(12'h000);
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        chk_bit(dev_quiet, 1'b0, "reset mode");
        // Second cycle after a change is the first that saw it whole
        for (k = 0; k < 14; k++) begin
            set_req(k == 12 ? 12'hfff : (k == 13 ? 12'h000 : 12'h001 << k));
            repeat (3) @(negedge clk);
            chk_bit(clk_req, 1'b0, "clock request in continuous mode");
            wait_lvl(irq_valid, 1'b1, 3000);
            wait_lvl(irq_valid, 1'b1, 3000);
            chk_vec(irq_seen, exp_seen, "frame map");
        end
        $display("test continuous frames done");
        quiet_next = 1'b1;
        wait_lvl(irq_valid, 1'b1, 3000);
        wait_lvl(dev_quiet, 1'b1, 200);
        chk_bit(host_quiet, 1'b1, "host mode");
        chk_bit(dev_quiet, 1'b1, "device mode");
        set_req(12'h004);
        @(negedge clk);
        chk_bit(clk_req, 1'b1, "clock request");
        chk_bit(link.clkrun, 1'b0, "clock-run wire");
        chk_bit(irq_busy, 1'b1, "busy");
        wait_lvl(irq_valid, 1'b1, 3000);
        chk_vec(irq_seen, exp_seen, "device started cycle");
        chk_bit(host_quiet, 1'b1, "mode kept");
        $display("test quiet request done");
        set_req(12'h001);
        @(negedge clk);
        chk_bit(clk_req, 1'b1, "second clock request");
        if_reset = 1'b1;
        @(negedge clk);
        if_reset = 1'b0;
        chk_bit(clk_req, 1'b0, "request cleared");
        chk_bit(irq_busy, 1'b0, "busy cleared");
        chk_bit(dev_quiet, 1'b1, "mode over interface reset");
        set_req(12'h000);
        quiet_next = 1'b0;
        // Let the brief clock-run burst pass before the host starts, so no stale request reaches the link
        repeat (4) @(negedge clk);
        start_req = 1'b1;
        wait_lvl(irq_valid, 1'b1, 3000);
        start_req = 1'b0;
        wait_lvl(dev_quiet, 1'b0, 200);
        chk_bit(host_quiet, 1'b0, "back to continuous");
        $display("test interface reset done");
        results();
    end
endmodule : test_serirq_slave_and_clock_request
